// ===== verilog/tcd_decoder.sv
// Purpose: command decoder of a two-wire thermometer/thermostat slave
// Assumes: a framer on link_clk delivers address, data, read and stop events
// Notes: each event is handed to core_clk by toggle handshake
// Overview of operation
// RULE1: A1h writes two high-limit bytes, reads them back
// RULE2: A2h writes two low-limit bytes, reads them back
// RULE3: ACh writes or reads one configuration byte
// RULE4: AAh reads two bytes of last conversion
// RULE5: A8h reads count-remaining byte
// RULE6: A9h reads slope accumulator byte
// RULE7: EEh in single mode converts once
// RULE8: EEh in continuous mode converts until stopped
// RULE9: 22h finishes current conversion, then idles
// RULE10: master restarts every single-mode conversion
// RULE11: master waits 10 ms after nonvolatile writes
// RULE12: acknowledge address, command and written data bytes
// RULE13: repeated start decodes a fresh command
// RULE14: config 02h gives active-high, continuous mode
// RULE15: single bit set means one conversion
// RULE16: busy flag high during nonvolatile write
// RULE17: master reads via command, repeated start, read
// RULE18: answer only address 1001 plus select pins
// RULE19: first byte is command, extra bytes ignored
module tcd_decoder
    import tcd_pkg::*;
#(
    parameter int NV_WR_CYC = NV_WR_CYCLES
) (
    input wire logic core_clk, // core clock
    input wire logic srst, // synchronous reset
    input wire logic link_clk, // framer clock
    input wire logic lk_ev_valid, // event offered
    input wire tcd_ev_t lk_ev, // event kind and byte
    output logic lk_busy, // event not yet answered
    output tcd_rsp_t lk_rsp, // ack and byte to send
    input wire logic [2:0] addr_sel, // address select pins
    output logic conv_start, // one-cycle conversion request
    input wire logic conv_done, // conversion finished
    input wire logic [15:0] temp_result, // finished temperature
    input wire logic [7:0] count_remain, // counter byte
    input wire logic [7:0] slope_accum, // slope byte
    output logic single_conversion_bit, // single mode
    output logic output_polarity_bit, // thermostat polarity
    output logic nonvolatile_busy_flag, // write in progress
    output logic [15:0] high_limit, // high threshold
    output logic [15:0] low_limit, // low threshold
    output logic conv_active // conversion running
);
    // link domain
    logic lk_rst_m_q;
    logic lk_rst_q;
    tcd_ev_t lk_ev_q;
    logic req_tog_q;
    logic dn_m_q;
    logic dn_s_q;
    logic dn_seen_q;
    tcd_rsp_t lk_rsp_q;
    // core domain
    logic rq_m_q;
    logic rq_s_q;
    logic rq_seen_q;
    logic done_tog_q;
    tcd_rsp_t rsp_q;
    logic [2:0] as_m_q;
    logic [2:0] as_q;
    tcd_phase_t ph_q;
    logic [7:0] cmd_q;
    logic [1:0] idx_q;
    logic [15:0] hi_q;
    logic [15:0] lo_q;
    logic [15:0] temp_q;
    logic [1:0] cfg_q;
    logic busy_q;
    logic go_q;
    logic one_q;
    logic done_q;
    logic nvb_q;
    logic [NV_CW-1:0] nv_cnt_q;

    // reset is carried over; link clock may be still, so it applies late
    always_ff @(posedge link_clk) begin
        lk_rst_m_q <= srst;
        lk_rst_q <= lk_rst_m_q;
    end

    wire lk_take = lk_ev_valid && !lk_busy;
    wire dn_new = dn_s_q != dn_seen_q;

    always_ff @(posedge link_clk) begin
        if (lk_rst_q) begin
            lk_ev_q <= '0;
            req_tog_q <= 1'b0;
            dn_m_q <= 1'b0;
            dn_s_q <= 1'b0;
            dn_seen_q <= 1'b0;
            lk_rsp_q <= '0;
        end else begin
            dn_m_q <= done_tog_q;
            dn_s_q <= dn_m_q;
            if (lk_take) begin
                lk_ev_q <= lk_ev;
                req_tog_q <= ~req_tog_q;
            end
            // answer word is stable once its toggle arrives
            if (dn_new) begin
                lk_rsp_q <= rsp_q;
                dn_seen_q <= dn_s_q;
            end
        end
    end

    assign lk_busy = req_tog_q != dn_seen_q;
    assign lk_rsp = lk_rsp_q;

    // event decode in core domain; event word held until answered
    wire ev_go = rq_s_q != rq_seen_q;
    wire [7:0] eb = lk_ev_q.data;
    wire ev_adr = ev_go && lk_ev_q.kind == EV_ADDR;
    wire ev_wd = ev_go && lk_ev_q.kind == EV_WDATA;
    wire ev_rd = ev_go && lk_ev_q.kind == EV_RDATA;
    wire ev_stp = ev_go && lk_ev_q.kind == EV_STOP;
    wire addr_hit = eb[7:4] == ADDR_FAMILY && eb[3:1] == as_q; // RULE18
    wire wr_cmd = ev_wd && ph_q == PH_CMD; // RULE19
    wire wr_dat = ev_wd && ph_q == PH_DATA;
    wire rd_dat = ev_rd && ph_q == PH_READ;
    wire cmd_start = wr_cmd && eb == CMD_START;
    wire cmd_stop = wr_cmd && eb == CMD_STOP;
    wire is_hi = cmd_q == CMD_HI;
    wire is_lo = cmd_q == CMD_LO;
    wire lim_wr = wr_dat && (is_hi || is_lo) && idx_q < 2'd2; // RULE19
    wire cfg_wr = wr_dat && cmd_q == CMD_CFG && idx_q == 2'd0; // RULE3
    wire nv_start = (lim_wr && idx_q == 2'd1) || cfg_wr; // RULE16
    wire nv_end = nv_cnt_q == NV_CW'(NV_WR_CYC - 1);
    wire ack_d = ev_adr ? addr_hit : (ev_wd && ph_q != PH_IDLE
        && ph_q != PH_READ); // RULE12

    // configuration byte as seen by a read
    logic [7:0] cfg_rd;
    always_comb begin
        cfg_rd = 8'h00;
        cfg_rd[CFG_SINGLE_BIT] = cfg_q[0];
        cfg_rd[CFG_POLARITY_BIT] = cfg_q[1];
        cfg_rd[CFG_NV_BUSY_BIT] = nvb_q;
        cfg_rd[CFG_DONE_BIT] = done_q;
    end

    wire two_b = is_hi || is_lo || cmd_q == CMD_TEMP;
    wire [15:0] rd_word = is_hi ? hi_q : is_lo ? lo_q : temp_q; // RULE4
    wire [7:0] one_v = cmd_q == CMD_CFG ? cfg_rd
        : cmd_q == CMD_CNT ? count_remain // RULE5
        : slope_accum; // RULE6
    wire one_b = cmd_q == CMD_CFG || cmd_q == CMD_CNT || cmd_q == CMD_SLOPE;
    wire [7:0] two_v = idx_q == 2'd0 ? rd_word[15:8]
        : idx_q == 2'd1 ? rd_word[7:0] : RD_IDLE_BYTE;
    wire [7:0] rd_byte = two_b ? two_v // RULE1
        : (one_b && idx_q == 2'd0) ? one_v : RD_IDLE_BYTE;

    // phase after the event
    wire tcd_phase_t ph_adr = !addr_hit ? PH_IDLE
        : eb[0] ? PH_READ : PH_CMD; // RULE13
    wire tcd_phase_t ph_d = ev_adr ? ph_adr
        : ev_stp ? PH_IDLE
        : wr_cmd ? PH_DATA : ph_q;
    wire [1:0] idx_d = (ev_adr || wr_cmd) ? 2'd0
        : ((wr_dat || rd_dat) && idx_q != 2'd3) ? idx_q + 2'd1 : idx_q;

    always_ff @(posedge core_clk) begin
        as_m_q <= addr_sel;
        as_q <= as_m_q;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rq_m_q <= 1'b0;
            rq_s_q <= 1'b0;
            rq_seen_q <= 1'b0;
            done_tog_q <= 1'b0;
            rsp_q <= '0;
        end else begin
            rq_m_q <= req_tog_q;
            rq_s_q <= rq_m_q;
            if (ev_go) begin
                rq_seen_q <= rq_s_q;
                done_tog_q <= ~done_tog_q;
                rsp_q.ack <= ack_d;
                rsp_q.data <= rd_dat ? rd_byte : RD_IDLE_BYTE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ph_q <= PH_IDLE;
            cmd_q <= CMD_RST;
            idx_q <= 2'd0;
        end else begin
            ph_q <= ph_d;
            idx_q <= idx_d;
            if (wr_cmd) begin
                cmd_q <= eb; // RULE13
            end
        end
    end

    // limits take the temperature byte order, high byte first
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hi_q <= LIMIT_RST;
            lo_q <= LIMIT_RST;
            cfg_q <= CFG_RST;
        end else begin
            if (lim_wr && is_hi && idx_q == 2'd0) hi_q[15:8] <= eb; // RULE1
            if (lim_wr && is_hi && idx_q == 2'd1) hi_q[7:0] <= eb; // RULE1
            if (lim_wr && is_lo && idx_q == 2'd0) lo_q[15:8] <= eb; // RULE2
            if (lim_wr && is_lo && idx_q == 2'd1) lo_q[7:0] <= eb; // RULE2
            if (cfg_wr) begin
                cfg_q <= {eb[CFG_POLARITY_BIT], eb[CFG_SINGLE_BIT]}; // RULE14
            end
        end
    end

    // writes during a busy cell are still taken; pacing is up to the master
    always_ff @(posedge core_clk) begin
        if (srst) begin
            nvb_q <= 1'b0;
            nv_cnt_q <= '0;
        end else if (nv_start) begin
            nvb_q <= 1'b1; // RULE16
            nv_cnt_q <= '0;
        end else if (nvb_q) begin
            nvb_q <= !nv_end; // RULE16
            nv_cnt_q <= nv_cnt_q + NV_CW'(1);
        end
    end

    wire single_m = cfg_q[0];
    assign conv_start = !busy_q && (go_q || one_q); // RULE8

    always_ff @(posedge core_clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            go_q <= 1'b0;
            one_q <= 1'b0;
            done_q <= 1'b0;
            temp_q <= TEMP_RST;
        end else begin
            if (cmd_start && !single_m) go_q <= 1'b1; // RULE8
            else if (cmd_stop) go_q <= 1'b0; // RULE9
            if (cmd_start && single_m) one_q <= 1'b1; // RULE15
            else if (conv_start || cmd_stop) one_q <= 1'b0; // RULE7
            // a stop leaves busy alone, so the running conversion ends
            if (conv_start) busy_q <= 1'b1; // RULE9
            else if (conv_done) busy_q <= 1'b0;
            if (conv_done) done_q <= 1'b1;
            else if (conv_start) done_q <= 1'b0;
            if (conv_done) temp_q <= temp_result; // RULE4
        end
    end

    assign single_conversion_bit = cfg_q[0];
    assign output_polarity_bit = cfg_q[1];
    assign nonvolatile_busy_flag = nvb_q;
    assign high_limit = hi_q;
    assign low_limit = lo_q;
    assign conv_active = busy_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    property p_hi_wr;
        lim_wr && is_hi && idx_q == 2'd1 |=> hi_q[7:0] == $past(eb)
            && hi_q[15:8] == $past(hi_q[15:8]);
    endproperty
    a_hi_wr: assert property (p_hi_wr) else $error("high limit low byte"); // RULE1

    property p_lo_wr;
        lim_wr && is_lo && idx_q == 2'd0 |=> lo_q[15:8] == $past(eb);
    endproperty
    a_lo_wr: assert property (p_lo_wr) else $error("low limit high byte"); // RULE2

    property p_cfg_wr;
        cfg_wr |=> single_conversion_bit == $past(eb[0])
            && output_polarity_bit == $past(eb[1]);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config write"); // RULE3

    property p_temp;
        conv_done |=> temp_q == $past(temp_result);
    endproperty
    a_temp: assert property (p_temp) else $error("temperature not held"); // RULE4

    property p_cnt;
        rd_dat && cmd_q == CMD_CNT && idx_q == 2'd0
            |=> rsp_q.data == $past(count_remain);
    endproperty
    a_cnt: assert property (p_cnt) else $error("counter byte"); // RULE5

    property p_slope;
        rd_dat && cmd_q == CMD_SLOPE && idx_q == 2'd0
            |=> rsp_q.data == $past(slope_accum);
    endproperty
    a_slope: assert property (p_slope) else $error("slope byte"); // RULE6

    property p_single;
        cmd_start && single_m && !busy_q && !go_q
            |=> conv_start ##1 (!conv_start && !one_q);
    endproperty
    a_single: assert property (p_single) else $error("single conversion"); // RULE7

    property p_cont;
        conv_done && go_q && !cmd_stop |=> conv_start;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous restart"); // RULE8

    property p_stop;
        cmd_stop && busy_q && !conv_done |=> busy_q && !go_q && !one_q;
    endproperty
    a_stop: assert property (p_stop) else $error("stop handling"); // RULE9

    property p_ack;
        ev_wd && (ph_q == PH_CMD || ph_q == PH_DATA) |=> rsp_q.ack;
    endproperty
    a_ack: assert property (p_ack) else $error("data byte not acked"); // RULE12

    property p_fresh;
        ev_adr && addr_hit && !eb[0] |=> ph_q == PH_CMD ##1 idx_q == 2'd0;
    endproperty
    a_fresh: assert property (p_fresh) else $error("command not fresh"); // RULE13

    property p_pol;
        cfg_wr && eb == 8'h02 |=> output_polarity_bit && !single_conversion_bit;
    endproperty
    a_pol: assert property (p_pol) else $error("config 02h"); // RULE14

    property p_nvb;
        nv_start |=> nonvolatile_busy_flag [*2];
    endproperty
    a_nvb: assert property (p_nvb) else $error("busy flag"); // RULE16

    property p_miss;
        ev_adr && !addr_hit |=> !rsp_q.ack && ph_q == PH_IDLE;
    endproperty
    a_miss: assert property (p_miss) else $error("foreign address acked"); // RULE18

    property p_extra;
        wr_dat && idx_q == 2'd2 |=> $stable(hi_q) && $stable(lo_q);
    endproperty
    a_extra: assert property (p_extra) else $error("extra byte stored"); // RULE19

    c_start: cover property (cmd_start);
    c_temp_rd: cover property (rd_dat && cmd_q == CMD_TEMP && idx_q == 2'd1);
    c_cfg: cover property (cfg_wr);
    c_miss: cover property (ev_adr && !addr_hit);
endmodule

// ===== verilog/tcd_pkg.sv
// Purpose: shared types and constants of the thermometer command decoder
// Assumes: core clock of 10 MHz
// Notes: link events come from a byte-level bus framer
package tcd_pkg;
    typedef enum logic [1:0] {
        EV_ADDR = 2'h0,
        EV_WDATA = 2'h1,
        EV_RDATA = 2'h2,
        EV_STOP = 2'h3
    } tcd_ev_kind_t;

    typedef struct packed {
        tcd_ev_kind_t kind;
        logic [7:0] data;
    } tcd_ev_t;

    typedef struct packed {
        logic ack;
        logic [7:0] data;
    } tcd_rsp_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_CMD = 2'b01,
        PH_DATA = 2'b11,
        PH_READ = 2'b10
    } tcd_phase_t;

    localparam logic [7:0] CMD_HI = 8'ha1;
    localparam logic [7:0] CMD_LO = 8'ha2;
    localparam logic [7:0] CMD_CFG = 8'hac;
    localparam logic [7:0] CMD_TEMP = 8'haa;
    localparam logic [7:0] CMD_CNT = 8'ha8;
    localparam logic [7:0] CMD_SLOPE = 8'ha9;
    localparam logic [7:0] CMD_START = 8'hee;
    localparam logic [7:0] CMD_STOP = 8'h22;
    localparam logic [3:0] ADDR_FAMILY = 4'h9;
    localparam int CFG_SINGLE_BIT = 0;
    localparam int CFG_POLARITY_BIT = 1;
    localparam int CFG_NV_BUSY_BIT = 4;
    localparam int CFG_DONE_BIT = 7;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [15:0] LIMIT_RST = 16'h0000;
    localparam logic [15:0] TEMP_RST = 16'h0000;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [7:0] RD_IDLE_BYTE = 8'hff;
    localparam int CLK_HZ = 10_000_000;
    localparam int NV_WR_TIME_MS = 10;
    localparam int NV_WR_CYCLES = NV_WR_TIME_MS * (CLK_HZ / 1000);
    localparam int NV_CW = 17;
endpackage

// ===== tb/tcd_master_model.sv
// Purpose: byte-level two-wire master standing at the framer port
// Assumes: one event at a time, offered on the falling link edge
// Notes: a released data field shows the inverse of the last byte
module tcd_master_model
    import tcd_pkg::*;
(
    input wire logic link_clk, // framer clock
    input wire logic lk_busy, // event not yet answered
    input wire tcd_rsp_t lk_rsp, // answer to last event
    output logic lk_ev_valid, // event offered
    output tcd_ev_t lk_ev // event kind and byte
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        lk_ev_valid = 1'b0;
        lk_ev = '{kind: EV_STOP, data: 8'h00};
    end
    task automatic xfer(input tcd_ev_kind_t k, input logic [7:0] d, output tcd_rsp_t r);
        int n;
        n = 0;
        @(negedge link_clk);
        lk_ev_valid = 1'b1;
        lk_ev = '{kind: k, data: d};
        // busy only moves on the rising edge, so the falling edge shows what gets sampled
        while (lk_busy !== 1'b0 && n < 500) begin
            @(negedge link_clk);
            n++;
        end
        // taken at this rising edge, held until it has passed
        @(posedge link_clk);
        @(negedge link_clk);
        lk_ev_valid = 1'b0;
        lk_ev.data = ~d;
        // answer is only trusted once busy has dropped
        while (lk_busy !== 1'b0 && n < 1000) begin
            @(negedge link_clk);
            n++;
        end
        r = lk_rsp;
    endtask
endmodule

// ===== tb/thermometer_command_decoder_tb.sv
// Purpose: self-checking bench of the thermometer command decoder
// Assumes: converter answers each start four core cycles later
// Notes: nonvolatile write time shortened to 20 core cycles
module thermometer_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tcd_pkg::*;
    localparam int NVC = 20;
    logic core_clk = 1'b0, link_clk = 1'b0, srst = 1'b1, conv_done = 1'b0;
    logic lk_ev_valid, lk_busy, conv_start, conv_active;
    logic single_conversion_bit, output_polarity_bit, nonvolatile_busy_flag;
    tcd_ev_t lk_ev;
    tcd_rsp_t lk_rsp;
    logic [2:0] addr_sel = 3'h0;
    logic [15:0] temp_result = 16'h0000, exp_temp = 16'h0000, high_limit, low_limit;
    logic [7:0] count_remain = 8'h00, slope_accum = 8'h00, q, adw;
    logic [7:0] lim_cmd[2] = '{CMD_HI, CMD_LO};
    int n_fail = 0, n_checks = 0, n_start = 0, cdly = 0;
    initial forever #50 core_clk = ~core_clk;
    initial begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    tcd_decoder #(.NV_WR_CYC(NVC)) u_tcd_decoder (.core_clk, .srst, .link_clk, .lk_ev_valid,
        .lk_ev, .lk_busy, .lk_rsp, .addr_sel, .conv_start, .conv_done, .temp_result,
        .count_remain, .slope_accum, .single_conversion_bit, .output_polarity_bit,
        .nonvolatile_busy_flag, .high_limit, .low_limit, .conv_active);
    tcd_master_model u_tcd_master_model (.link_clk, .lk_busy, .lk_rsp, .lk_ev_valid, .lk_ev);
    // converter stand-in; done only ever follows a start
    always @(negedge core_clk) begin
        conv_done = 1'b0;
        if (cdly > 0) begin
            cdly--;
            if (cdly == 0) begin
                conv_done = 1'b1;
                exp_temp = temp_result;
            end
        end
        if (conv_start === 1'b1) begin
            n_start++;
            cdly = 4;
            temp_result = 16'($urandom);
        end
    end
    task automatic chk_val(logic [15:0] got, logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(logic got, logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge core_clk);
    endtask
    // ack of x means the answer's ack is not judged
    task automatic ev(tcd_ev_kind_t k, logic [7:0] d, logic ack);
        tcd_rsp_t r;
        u_tcd_master_model.xfer(k, d, r);
        if (ack !== 1'bx) chk_bit(r.ack, ack);
        q = r.data;
    endtask
    task automatic stp();
        ev(EV_STOP, 8'h00, 1'b0);
    endtask
    task automatic wcmd(logic [7:0] c, logic [15:0] v, int nb);
        logic [23:0] b;
        b = {v, 8'h77};
        ev(EV_ADDR, adw, 1'b1);
        ev(EV_WDATA, c, 1'b1);
        for (int i = 0; i < nb; i++) begin
            ev(EV_WDATA, b[23 - 8 * i -: 8], 1'b1);
        end
    endtask
    // one read past the count, which must come back as ffh
    task automatic rcmd(logic [7:0] c, int nb, logic [15:0] v);
        logic [23:0] b;
        b = (nb == 2) ? {v, 8'hff} : {v[7:0], 8'hff, 8'hff};
        wcmd(c, 16'h0000, 0);
        ev(EV_ADDR, adw | 8'h01, 1'b1);
        for (int i = 0; i <= nb; i++) begin
            ev(EV_RDATA, 8'h00, 1'bx);
            chk_val({8'h00, q}, {8'h00, b[23 - 8 * i -: 8]});
        end
        stp();
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400us;
        n_fail++;
        end_of_test();
    end
    initial begin
        logic [15:0] v;
        int n0;
        void'($urandom(8903));
        addr_sel = 3'($urandom);
        adw = {ADDR_FAMILY, addr_sel, 1'b0};
        cyc(10);
        srst = 1'b0;
        cyc(2);
        wcmd(CMD_CFG, 16'h0200, 1);
        stp();
        chk_bit(output_polarity_bit, 1'b1);
        chk_bit(single_conversion_bit, 1'b0);
        chk_bit(nonvolatile_busy_flag, 1'b1);
        cyc(NVC + 5);
        chk_bit(nonvolatile_busy_flag, 1'b0);
        rcmd(CMD_CFG, 1, 16'h0002);
        foreach (lim_cmd[j]) begin
            v = 16'($urandom);
            wcmd(lim_cmd[j], v, 3);
            stp();
            chk_val(j ? low_limit : high_limit, v);
            cyc(NVC + 5);
            rcmd(lim_cmd[j], 2, v);
        end
        cyc(1);
        count_remain = 8'($urandom);
        slope_accum = 8'($urandom);
        rcmd(CMD_CNT, 1, {8'h00, count_remain});
        rcmd(CMD_SLOPE, 1, {8'h00, slope_accum});
        n0 = n_start;
        wcmd(CMD_START, 16'h0000, 0);
        stp();
        cyc(30);
        chk_bit(n_start > n0 + 2, 1'b1);
        wcmd(CMD_STOP, 16'h0000, 0);
        stp();
        cyc(8);
        n0 = n_start;
        cyc(30);
        chk_val(16'(n_start - n0), 16'h0000);
        chk_bit(conv_active, 1'b0);
        rcmd(CMD_TEMP, 2, exp_temp);
        wcmd(CMD_CFG, 16'h0100, 1);
        stp();
        cyc(NVC + 5);
        chk_bit(single_conversion_bit, 1'b1);
        for (int k = 0; k < 2; k++) begin
            n0 = n_start;
            wcmd(CMD_START, 16'h0000, 0);
            stp();
            cyc(30);
            chk_val(16'(n_start - n0), 16'h0001);
        end
        ev(EV_ADDR, adw ^ 8'h80, 1'b0);
        ev(EV_ADDR, adw ^ 8'h02, 1'b0);
        ev(EV_WDATA, CMD_CFG, 1'b0);
        ev(EV_WDATA, 8'h02, 1'b0);
        stp();
        cyc(5);
        chk_bit(output_polarity_bit, 1'b0);
        end_of_test();
    end
endmodule
